// ===== rtl/tam_pkg.sv
// tam_pkg: constants and carrier types for the temperature alert monitor
// assumes process values arrive as signed 16-bit words in tenths of a unit
package tam_pkg;
   localparam int unsigned CH_NUM = 4;
   localparam int unsigned PV_W = 16;
   localparam logic [15:0] MODE_TEMP_INPUT = 16'h0100;
   // per-type enable: 0 enables, 1 disables (the reset default)
   localparam logic EN_CODE = 1'b0;
   localparam logic EN_RESET = 1'b1;
   // alert detail bit positions
   localparam int unsigned DET_PROC_UP = 2;
   localparam int unsigned DET_PROC_LO = 3;
   localparam int unsigned DET_RATE_UP = 4;
   localparam int unsigned DET_RATE_LO = 5;
   localparam logic [15:0] DET_RESET = 16'h0000;
   // integer resolution: tenths per whole unit and half of it for rounding
   localparam logic signed [17:0] RES_TEN = 18'sh0000a;
   localparam logic signed [17:0] RES_HALF = 18'sh00005;
   localparam logic [15:0] CYC_RESET = 16'h0001;

   typedef struct packed {
      logic signed [15:0] uu;
      logic signed [15:0] ul;
      logic signed [15:0] lu;
      logic signed [15:0] ll;
   } tam_proc_lim_type;

   typedef struct packed {
      logic signed [15:0] up;
      logic signed [15:0] lo;
      logic [15:0] cycles;
   } tam_rate_lim_type;

   typedef struct packed {
      logic proc_en_n;
      logic rate_en_n;
   } tam_en_type;

   typedef enum logic [1:0] {
      TAM_RS_IDLE = 2'b00,
      TAM_RS_REF = 2'b01,
      TAM_RS_RUN = 2'b11
   } tam_rs_type;
endpackage

// ===== rtl/tam_chan.sv
// tam_chan: alarm evaluation of one measuring channel
// assumes pv_vld marks a fresh sample once per sampling cycle
`timescale 1ns/1ps
module tam_chan #(
   parameter int unsigned PV_W = 16
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic active,
   input wire logic res_int,
   input wire logic pv_vld,
   input wire logic signed [PV_W-1:0] pv,
   input wire tam_pkg::tam_proc_lim_type proc_lim,
   input wire tam_pkg::tam_rate_lim_type rate_lim,
   input wire tam_pkg::tam_en_type en,
   output logic [15:0] detail,
   output logic alert
);
   logic signed [PV_W+1:0] pv_ext;
   logic signed [PV_W+1:0] pv_biased;
   logic signed [PV_W-1:0] pv_use;
   logic signed [PV_W:0] diff;
   logic proc_on;
   logic rate_on;
   logic p_up_r, p_up_nxt, p_lo_r, p_lo_nxt;
   logic r_up_r, r_up_nxt, r_lo_r, r_lo_nxt;
   logic signed [PV_W-1:0] prev_r, prev_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   tam_pkg::tam_rs_type rs_r, rs_nxt;

   ////////////////////////////////////////////////////////////////////////
   // round to whole unit
   always_comb begin
      pv_ext = (PV_W+2)'(pv);
      pv_biased = (pv_ext < 0) ? pv_ext - tam_pkg::RES_HALF : pv_ext + tam_pkg::RES_HALF;
      pv_use = res_int ? PV_W'((pv_biased / tam_pkg::RES_TEN) * tam_pkg::RES_TEN) : pv;
   end

   assign proc_on = active && (en.proc_en_n == tam_pkg::EN_CODE);
   assign rate_on = active && (en.rate_en_n == tam_pkg::EN_CODE);
   assign diff = (PV_W+1)'(pv_use) - (PV_W+1)'(prev_r);

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      p_up_nxt = p_up_r;
      p_lo_nxt = p_lo_r;
      r_up_nxt = r_up_r;
      r_lo_nxt = r_lo_r;
      prev_nxt = prev_r;
      cnt_nxt = cnt_r;
      rs_nxt = rs_r;
      // no error-reset path: only own conditions, disable or leaving the mode clear alarms
      if (!proc_on) begin
         p_up_nxt = 1'b0;
         p_lo_nxt = 1'b0;
      end else if (pv_vld) begin
         if (pv_use >= proc_lim.uu) begin
            p_up_nxt = 1'b1;
         end else if (pv_use < proc_lim.ul) begin
            p_up_nxt = 1'b0;
         end
         if (pv_use <= proc_lim.ll) begin
            p_lo_nxt = 1'b1;
         end else if (pv_use > proc_lim.lu) begin
            p_lo_nxt = 1'b0;
         end
      end
      if (!rate_on) begin
         r_up_nxt = 1'b0;
         r_lo_nxt = 1'b0;
         rs_nxt = tam_pkg::TAM_RS_IDLE;
      end else begin
         case (rs_r)
            tam_pkg::TAM_RS_IDLE: begin
               rs_nxt = tam_pkg::TAM_RS_REF;
               cnt_nxt = 16'h0000;
            end
            tam_pkg::TAM_RS_REF: begin
               if (pv_vld) begin
                  prev_nxt = pv_use;
                  cnt_nxt = 16'h0000;
                  rs_nxt = tam_pkg::TAM_RS_RUN;
               end
            end
            tam_pkg::TAM_RS_RUN: begin
               if (pv_vld) begin
                  cnt_nxt = cnt_r + 16'h0001;
                  if (cnt_nxt >= rate_lim.cycles) begin
                     cnt_nxt = 16'h0000;
                     prev_nxt = pv_use;
                     r_up_nxt = diff >= (PV_W+1)'(rate_lim.up);
                     r_lo_nxt = diff <= (PV_W+1)'(rate_lim.lo);
                  end
               end
            end
            default: rs_nxt = tam_pkg::TAM_RS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         p_up_r <= 1'b0;
         p_lo_r <= 1'b0;
         r_up_r <= 1'b0;
         r_lo_r <= 1'b0;
         prev_r <= '0;
         cnt_r <= 16'h0000;
         rs_r <= tam_pkg::TAM_RS_IDLE;
      end else begin
         p_up_r <= p_up_nxt;
         p_lo_r <= p_lo_nxt;
         r_up_r <= r_up_nxt;
         r_lo_r <= r_lo_nxt;
         prev_r <= prev_nxt;
         cnt_r <= cnt_nxt;
         rs_r <= rs_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // process bits b2 b3, rate bits b4 b5
   always_comb begin
      detail = tam_pkg::DET_RESET;
      detail[tam_pkg::DET_PROC_UP] = p_up_r;
      detail[tam_pkg::DET_PROC_LO] = p_lo_r;
      detail[tam_pkg::DET_RATE_UP] = r_up_r;
      detail[tam_pkg::DET_RATE_LO] = r_lo_r;
   end
   assign alert = p_up_r | p_lo_r | r_up_r | r_lo_r;
endmodule // tam_chan

// ===== rtl/tam_top.sv
// tam_top: four-channel alert monitor of a temperature input unit
// assumes limits and enables are held by the network slave as plain words
// Function
// - temperature-input mode code selects measuring and alarm evaluation
// - process alarm when value at or above upper-upper, at or below lower-lower
// - upper clears below upper-lower; lower clears above lower-upper
// - error reset never clears an active alarm
// - any active alarm sets channel alert flag and lights shared indicator
// - detail bit b2 upper process, b3 lower process, cleared with alarm
// - detail bit b4 upper rate, b5 lower rate, cleared with alarm
// - flag and indicator drop only when no alarm remains
// - sample once per detection cycle, difference present minus previous
// - rate alarm when difference reaches upper or lower rate limit
// - rate alarm clears once difference lies strictly between limits
// - flashing error indication takes precedence over steady alarm light
// - each alarm type evaluated only with its enable code, default disabled
// - integer resolution rounds value before alarm decisions
`timescale 1ns/1ps
module tam_top #(
   parameter int unsigned CH_NUM = tam_pkg::CH_NUM,
   parameter int unsigned PV_W = tam_pkg::PV_W
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [15:0] ctrl_mode,
   input wire logic res_int,
   input wire logic err_reset_req,
   input wire logic flash_err,
   input wire logic flash_phase,
   input wire logic pv_vld,
   input wire logic [CH_NUM*PV_W-1:0] pv_all,
   input wire tam_pkg::tam_proc_lim_type [CH_NUM-1:0] proc_lim,
   input wire tam_pkg::tam_rate_lim_type [CH_NUM-1:0] rate_lim,
   input wire tam_pkg::tam_en_type [CH_NUM-1:0] en,
   output logic [CH_NUM-1:0] channel_alert_flag,
   output logic [CH_NUM*16-1:0] alert_detail_word,
   output logic alarm_indicator,
   output logic temp_input_active
);
   logic active_r, active_nxt;
   logic [CH_NUM-1:0] alert_w;
   logic [CH_NUM*16-1:0] detail_w;
   logic ind_nxt, ind_r;

   ////////////////////////////////////////////////////////////////////////
   // mode selection
   always_comb begin
      active_nxt = (ctrl_mode == tam_pkg::MODE_TEMP_INPUT);
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         active_r <= 1'b0;
      end else begin
         active_r <= active_nxt;
      end
   end
   assign temp_input_active = active_r;

   ////////////////////////////////////////////////////////////////////////
   // err_reset_req deliberately not routed to alarm state
   genvar g;
   generate
      for (g = 0; g < CH_NUM; g++) begin : g_ch
         tam_chan #(.PV_W(PV_W)) u_chan (
            .clk_sys(clk_sys),
            .reset(reset),
            .active(active_r),
            .res_int(res_int),
            .pv_vld(pv_vld),
            .pv(pv_all[g*PV_W +: PV_W]),
            .proc_lim(proc_lim[g]),
            .rate_lim(rate_lim[g]),
            .en(en[g]),
            .detail(detail_w[g*16 +: 16]),
            .alert(alert_w[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // flag and indicator on any alarm
   always_comb begin
      ind_nxt = flash_err ? flash_phase : (|alert_w);
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         channel_alert_flag <= '0;
         alert_detail_word <= '0;
         ind_r <= 1'b0;
      end else begin
         channel_alert_flag <= alert_w;
         alert_detail_word <= detail_w;
         ind_r <= ind_nxt;
      end
   end
   assign alarm_indicator = ind_r;
   logic unused_ok;
   assign unused_ok = err_reset_req;
endmodule // tam_top

// ===== sim/tam_chk.sv
// tam_chk: port-level assertions for tam_top
// assumes bind from the bench top, one clock domain
`timescale 1ns/1ps
module tam_chk #(
   parameter int unsigned CH_NUM = 4
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [15:0] ctrl_mode,
   input wire logic flash_err,
   input wire logic flash_phase,
   input wire tam_pkg::tam_en_type [CH_NUM-1:0] en,
   input wire logic [CH_NUM-1:0] channel_alert_flag,
   input wire logic [CH_NUM*16-1:0] alert_detail_word,
   input wire logic alarm_indicator,
   input wire logic temp_input_active
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////
   a_mode_latch: assert property (
      !$past(reset) |-> temp_input_active == $past(ctrl_mode == tam_pkg::MODE_TEMP_INPUT))
      else $error("mode flag does not follow control mode");
   a_mode_off: assert property (
      (ctrl_mode != tam_pkg::MODE_TEMP_INPUT) [*4] |-> alert_detail_word == '0)
      else $error("alarm outside temperature input mode");
   a_flag_detail: assert property (
      channel_alert_flag[0] == |alert_detail_word[5:2]) else $error("flag disagrees with detail");
   a_ind_steady: assert property (
      !flash_err [*3] |-> alarm_indicator == |channel_alert_flag) else $error("indicator disagrees with flags");
   a_flash_shows: assert property (
      (flash_err && $stable(flash_phase)) [*3] |-> alarm_indicator == flash_phase)
      else $error("flash pattern not shown");
   a_resv_bits: assert property (
      (alert_detail_word & {CH_NUM{16'hffc3}}) == '0) else $error("unused detail bit set");
   a_proc_off: assert property (
      en[0].proc_en_n [*4] |-> alert_detail_word[3:2] == 2'h0) else $error("disabled process alarm set");
   a_rate_off: assert property (
      en[0].rate_en_n [*4] |-> alert_detail_word[5:4] == 2'h0) else $error("disabled rate alarm set");
endmodule // tam_chk

// ===== sim/tam_master.sv
// tam_master: network master holding limits, enables and mode
// assumes tasks are called by the bench off the rising edge
`timescale 1ns/1ps
module tam_master (
   output logic [15:0] ctrl_mode,
   output logic res_int,
   output tam_pkg::tam_proc_lim_type [3:0] proc_lim,
   output tam_pkg::tam_rate_lim_type [3:0] rate_lim,
   output tam_pkg::tam_en_type [3:0] en
);
   // uu 1000, ul 900, lu 100, ll 0; rate +200 / -200 every sample
   initial begin
      ctrl_mode = 16'h0000;
      res_int = 1'b0;
      en = '1;
      proc_lim = {4{64'h03e8_0384_0064_0000}};
      rate_lim = {4{48'h00c8_ff38_0001}};
   end
   task automatic cfg(input logic [15:0] m, input logic p, input logic r, input logic i);
      ctrl_mode = m;
      res_int = i;
      en = {4{p, r}};
      // settle time so mode latch and reference state are ready
      repeat (4) @(negedge tb_top.clk_sys);
   endtask
   // samples per rate check on every channel; applies at once to the count in progress
   task automatic rate_cyc(input logic [15:0] c);
      for (int i = 0; i < 4; i++) begin
         rate_lim[i].cycles = c;
      end
   endtask
endmodule // tam_master

// ===== sim/tb_top.sv
// tb_top: directed bench for tam_top
// assumes tam_master supplies configuration; bench drives samples
`timescale 1ns/1ps
module tb_top;
   localparam logic [15:0] M = tam_pkg::MODE_TEMP_INPUT;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic err_reset_req = 1'b0;
   logic flash_err = 1'b0;
   logic flash_phase = 1'b0;
   logic pv_vld = 1'b0;
   logic [63:0] pv_all = 64'h0;
   logic [15:0] ctrl_mode;
   logic res_int;
   tam_pkg::tam_proc_lim_type [3:0] proc_lim;
   tam_pkg::tam_rate_lim_type [3:0] rate_lim;
   tam_pkg::tam_en_type [3:0] en;
   logic [3:0] channel_alert_flag;
   logic [63:0] alert_detail_word;
   logic alarm_indicator;
   logic temp_input_active;
   int n_errors = 0;
   int samples_checked = 0;
   always #2.5 clk_sys = ~clk_sys;
   tam_master i_tam_master (.ctrl_mode(ctrl_mode), .res_int(res_int), .proc_lim(proc_lim),
      .rate_lim(rate_lim), .en(en));
   tam_top i_tam_top (.clk_sys(clk_sys), .reset(reset), .ctrl_mode(ctrl_mode), .res_int(res_int),
      .err_reset_req(err_reset_req), .flash_err(flash_err), .flash_phase(flash_phase), .pv_vld(pv_vld),
      .pv_all(pv_all), .proc_lim(proc_lim), .rate_lim(rate_lim), .en(en),
      .channel_alert_flag(channel_alert_flag), .alert_detail_word(alert_detail_word),
      .alarm_indicator(alarm_indicator), .temp_input_active(temp_input_active));
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one sample on all channels, answer looked at three falling edges after it is driven
   task automatic samp(input logic [15:0] v, input logic [15:0] d);
      @(negedge clk_sys);
      pv_vld = 1'b1;
      pv_all = {4{v}};
      @(negedge clk_sys);
      pv_vld = 1'b0;
      pv_all = ~pv_all;
      repeat (2) @(negedge clk_sys);
      check(alert_detail_word, {4{d}});
      check({channel_alert_flag, alarm_indicator}, {{4{|d}}, |d});
   endtask
   task automatic results;
      if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(negedge clk_sys);
      reset = 1'b0;
      check(alert_detail_word, 64'h0);
      i_tam_master.cfg(M, 1'b0, 1'b1, 1'b0);
      check(temp_input_active, 1'b1);
      samp(16'h01f4, 16'h0000);
      samp(16'h03e8, 16'h0004);
      err_reset_req = 1'b1;
      samp(16'h03b6, 16'h0004);
      samp(16'h0383, 16'h0000);
      err_reset_req = 1'b0;
      samp(16'h0000, 16'h0008);
      samp(16'h0064, 16'h0008);
      samp(16'h0065, 16'h0000);
      i_tam_master.cfg(M, 1'b0, 1'b0, 1'b0);
      samp(16'h01f4, 16'h0000);
      samp(16'h02bc, 16'h0010);
      samp(16'h0383, 16'h0000);
      samp(16'h02bb, 16'h0020);
      samp(16'h0258, 16'h0000);
      // two samples per check: the middle sample must not be compared
      i_tam_master.rate_cyc(16'h0002);
      samp(16'h02bc, 16'h0000);
      samp(16'h0320, 16'h0010);
      i_tam_master.cfg(M, 1'b0, 1'b1, 1'b1);
      samp(16'h01f4, 16'h0000);
      samp(16'h03e3, 16'h0004);
      flash_err = 1'b1;
      repeat (3) @(negedge clk_sys);
      check(alarm_indicator, 1'b0);
      flash_phase = 1'b1;
      repeat (2) @(negedge clk_sys);
      check(alarm_indicator, 1'b1);
      flash_phase = 1'b0;
      flash_err = 1'b0;
      samp(16'h01f4, 16'h0000);
      i_tam_master.cfg(M, 1'b1, 1'b1, 1'b0);
      samp(16'h03e8, 16'h0000);
      i_tam_master.cfg(16'h0000, 1'b0, 1'b0, 1'b0);
      samp(16'h03e8, 16'h0000);
      results;
   end
   initial begin
      #20000;
      n_errors++;
      results;
   end
endmodule // tb_top
bind tam_top tam_chk #(.CH_NUM(CH_NUM)) i_tam_chk (.clk_sys(clk_sys), .reset(reset), .ctrl_mode(ctrl_mode),
   .flash_err(flash_err), .flash_phase(flash_phase), .en(en), .channel_alert_flag(channel_alert_flag),
   .alert_detail_word(alert_detail_word), .alarm_indicator(alarm_indicator),
   .temp_input_active(temp_input_active));
